// *** logic/sram_link_params.svh ***
// constants shared by both ends of the burst sram link
`ifndef SRAM_LINK_PARAMS_SVH
`define SRAM_LINK_PARAMS_SVH

`define LANE_W 9
`define LANES 4
`define DATA_W 36
`define ADDR_W 18
`define BURST_LEN 4
`define BURST_IDX_W 2
`define SYNC_STAGES 3
`define K_HALF_CYCLES 6
`define TICK_W 4
`define RD_FIRST_TICK 4'h5
`define RD_LAST_TICK 4'h8
`define WR_FIRST_TICK 4'h2
`define WR_LAST_TICK 4'h5
`define SCHED_LEN 6

`endif

// *** logic/sram_link_pkg.sv ***
// types shared by both ends of the burst sram link
`include "sram_link_params.svh"

package sram_link_pkg;
	typedef logic [`DATA_W-1:0] word_type;
	typedef logic [`LANES-1:0] lane_mask_type;
	typedef logic [`ADDR_W-1:0] addr_type;
	typedef logic [`BURST_LEN*`DATA_W-1:0] burst_type;
	typedef logic [`BURST_LEN*`LANES-1:0] burst_mask_type;
	typedef logic [`TICK_W-1:0] tick_type;
	typedef enum {CMD_NONE, CMD_READ, CMD_WRITE, CMD_BOTH} cmd_kind_type;
endpackage

// *** logic/sram_link_if.sv ***
// pins between the memory controller and the burst sram
`timescale 1ns/10ps
`default_nettype none
`include "sram_link_params.svh"

interface sram_link_if;
	logic in_clk_true;
	logic in_clk_inverse;
	logic read_sel_n;
	logic write_sel_n;
	logic loop_bypass_n;
	logic [`ADDR_W-1:0] sync_addr_bus;
	logic [`DATA_W-1:0] wr_data_bus;
	logic [`LANES-1:0] byte_lane_write_n;
	logic [`DATA_W-1:0] rd_data_bus;
	logic rd_data_oe;
	logic echo_timing_true;
	logic echo_timing_inverse;

	modport device_end (
		input in_clk_true, in_clk_inverse, read_sel_n, write_sel_n,
		input loop_bypass_n, sync_addr_bus, wr_data_bus, byte_lane_write_n,
		output rd_data_bus, rd_data_oe, echo_timing_true, echo_timing_inverse
	);
	modport host_end (
		output in_clk_true, in_clk_inverse, read_sel_n, write_sel_n,
		output loop_bypass_n, sync_addr_bus, wr_data_bus, byte_lane_write_n,
		input rd_data_bus, rd_data_oe, echo_timing_true, echo_timing_inverse
	);
endinterface

`default_nettype wire

// *** logic/sram_device_end.sv ***
// burst-of-four sram: command capture, memory array and read launch
// Operation
// - address registered on true clock rise when selected
// - each transaction moves four words from one address
// - no select means address ignored, nothing starts
// - read select low starts four-word read burst
// - accepted select ignored on the next true rise
// - write select low starts four-word write burst
// - only lanes with low enable are stored
// - lane enables sampled with their own data word
// - control on true rise, data on both rises
// - host drives inverse clock opposite the true clock
// - write words 1,3 on true rise, 2,4 on inverse
// - read data timed from the input clock pair
// - low bypass input skips the delay loop
// - echo clocks run even while data is off
// - all thirty-six data bits are used
`timescale 1ns/10ps
`default_nettype none
`include "sram_link_params.svh"

module sram_device_end #(
	parameter int ADDR_W = `ADDR_W,
	parameter int LANE_W = `LANE_W,
	parameter int LANES = `LANES
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link pins
	sram_link_if.device_end link,
	// status
	output logic dll_bypassed_reg,
	output logic rd_busy_reg,
	output logic wr_busy_reg
);
	import sram_link_pkg::*;

	localparam int DATA_W = LANE_W * LANES;
	localparam int IN_W = 5 + ADDR_W + DATA_W + LANES;
	localparam int K_BIT = IN_W - 1;
	localparam int KN_BIT = IN_W - 2;
	localparam int RD_BIT = IN_W - 3;
	localparam int WR_BIT = IN_W - 4;
	localparam int BYP_BIT = IN_W - 5;
	localparam int MEM_DEPTH = 1 << (ADDR_W + `BURST_IDX_W);

	logic [IN_W-1:0] in_vec;
	logic [IN_W-1:0] sync1_reg;
	logic [IN_W-1:0] sync2_reg;
	logic [IN_W-1:0] sync3_reg;
	logic k_stable_reg;
	logic kn_stable_reg;
	logic k_rise;
	logic kn_rise;
	logic half_tick;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic [LANES-1:0] lane_n_s;
	logic rd_go;
	logic wr_go;
	logic rd_block_reg;
	logic wr_block_reg;
	logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
	logic rd_act_reg [0:1];
	tick_type rd_cnt_reg [0:1];
	logic [DATA_W-1:0] rd_buf_reg [0:1][0:`BURST_LEN-1];
	logic rd_ptr_reg;
	logic wr_act_reg [0:1];
	tick_type wr_cnt_reg [0:1];
	logic [ADDR_W-1:0] wr_addr_reg [0:1];
	logic wr_ptr_reg;
	logic [DATA_W-1:0] q_stage_reg;
	logic oe_stage_reg;
	logic [DATA_W-1:0] q_dly_reg;
	logic oe_dly_reg;
	logic echo_t_dly_reg;
	logic echo_i_dly_reg;
	logic [DATA_W-1:0] q_out_reg;
	logic oe_out_reg;
	logic echo_t_reg;
	logic echo_i_reg;

	// every pin input goes through three flops; all bits share the delay
	assign in_vec = {link.in_clk_true, link.in_clk_inverse, link.read_sel_n,
		link.write_sel_n, link.loop_bypass_n, link.sync_addr_bus,
		link.wr_data_bus, link.byte_lane_write_n};

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			sync3_reg <= '1;
		end
		else
		begin
			sync1_reg <= in_vec;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign addr_s = sync3_reg[DATA_W+LANES +: ADDR_W];
	assign data_s = sync3_reg[LANES +: DATA_W];
	assign lane_n_s = sync3_reg[LANES-1:0];

	// clock levels change only once stages two and three agree
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			k_stable_reg <= 1'b1;
			kn_stable_reg <= 1'b1;
		end
		else
		begin
			if (sync2_reg[K_BIT] == sync3_reg[K_BIT])
				k_stable_reg <= sync3_reg[K_BIT];
			if (sync2_reg[KN_BIT] == sync3_reg[KN_BIT])
				kn_stable_reg <= sync3_reg[KN_BIT];
		end
	end

	assign k_rise = sync2_reg[K_BIT] & sync3_reg[K_BIT] & ~k_stable_reg;
	assign kn_rise = sync2_reg[KN_BIT] & sync3_reg[KN_BIT] & ~kn_stable_reg;
	assign half_tick = k_rise | kn_rise;

	// selects are looked at only on true rises; a taken select blocks the next
	assign rd_go = k_rise & ~sync3_reg[RD_BIT] & ~rd_block_reg;
	assign wr_go = k_rise & ~sync3_reg[WR_BIT] & ~wr_block_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rd_block_reg <= 1'b0;
			wr_block_reg <= 1'b0;
		end
		else if (k_rise)
		begin
			rd_block_reg <= rd_go;
			wr_block_reg <= wr_go;
		end
	end

	// read slots: burst is copied out at accept, launched on later half ticks
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rd_ptr_reg <= 1'b0;
			for (int s = 0; s < 2; s++)
			begin
				rd_act_reg[s] <= 1'b0;
				rd_cnt_reg[s] <= '0;
			end
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (rd_act_reg[s] && half_tick)
				begin
					rd_cnt_reg[s] <= rd_cnt_reg[s] + 4'h1;
					if (rd_cnt_reg[s] + 4'h1 == `RD_LAST_TICK)
						rd_act_reg[s] <= 1'b0;
				end
			end
			if (rd_go)
			begin
				rd_act_reg[rd_ptr_reg] <= 1'b1;
				rd_cnt_reg[rd_ptr_reg] <= '0;
				rd_ptr_reg <= ~rd_ptr_reg;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rd_go)
		begin
			for (int w = 0; w < `BURST_LEN; w++)
				rd_buf_reg[rd_ptr_reg][w] <= mem[{addr_s, w[`BURST_IDX_W-1:0]}];
		end
	end

	// write slots: four words land on half ticks two to five after the accept
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_ptr_reg <= 1'b0;
			for (int s = 0; s < 2; s++)
			begin
				wr_act_reg[s] <= 1'b0;
				wr_cnt_reg[s] <= '0;
				wr_addr_reg[s] <= '0;
			end
		end
		else
		begin
			for (int s = 0; s < 2; s++)
			begin
				if (wr_act_reg[s] && half_tick)
				begin
					wr_cnt_reg[s] <= wr_cnt_reg[s] + 4'h1;
					if (wr_cnt_reg[s] + 4'h1 == `WR_LAST_TICK)
						wr_act_reg[s] <= 1'b0;
				end
			end
			if (wr_go)
			begin
				wr_act_reg[wr_ptr_reg] <= 1'b1;
				wr_cnt_reg[wr_ptr_reg] <= '0;
				wr_addr_reg[wr_ptr_reg] <= addr_s;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		for (int s = 0; s < 2; s++)
		begin
			if (wr_act_reg[s] && half_tick && wr_cnt_reg[s] + 4'h1 >= `WR_FIRST_TICK
				&& wr_cnt_reg[s] + 4'h1 <= `WR_LAST_TICK)
			begin
				for (int l = 0; l < LANES; l++)
				begin
					if (!lane_n_s[l])
						mem[{wr_addr_reg[s], 2'(wr_cnt_reg[s] + 4'h1
							- `WR_FIRST_TICK)}][l*LANE_W +: LANE_W] <=
							data_s[l*LANE_W +: LANE_W];
				end
			end
		end
	end

	// read launch: word k leaves on half tick five plus k after the accept
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			q_stage_reg <= '0;
			oe_stage_reg <= 1'b0;
		end
		else if (half_tick)
		begin
			oe_stage_reg <= 1'b0;
			for (int s = 0; s < 2; s++)
			begin
				if (rd_act_reg[s] && rd_cnt_reg[s] + 4'h1 >= `RD_FIRST_TICK)
				begin
					oe_stage_reg <= 1'b1;
					q_stage_reg <= rd_buf_reg[s][2'(rd_cnt_reg[s] + 4'h1
						- `RD_FIRST_TICK)];
				end
			end
		end
	end

	// with the loop bypassed outputs leave one cycle later than aligned
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			q_dly_reg <= '0;
			oe_dly_reg <= 1'b0;
			echo_t_dly_reg <= 1'b1;
			echo_i_dly_reg <= 1'b1;
			q_out_reg <= '0;
			oe_out_reg <= 1'b0;
			echo_t_reg <= 1'b1;
			echo_i_reg <= 1'b1;
		end
		else
		begin
			q_dly_reg <= q_stage_reg;
			oe_dly_reg <= oe_stage_reg;
			echo_t_dly_reg <= k_stable_reg;
			echo_i_dly_reg <= kn_stable_reg;
			if (!sync3_reg[BYP_BIT])
			begin
				q_out_reg <= q_dly_reg;
				oe_out_reg <= oe_dly_reg;
				echo_t_reg <= echo_t_dly_reg;
				echo_i_reg <= echo_i_dly_reg;
			end
			else
			begin
				q_out_reg <= q_stage_reg;
				oe_out_reg <= oe_stage_reg;
				echo_t_reg <= k_stable_reg;
				echo_i_reg <= kn_stable_reg;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			dll_bypassed_reg <= 1'b0;
			rd_busy_reg <= 1'b0;
			wr_busy_reg <= 1'b0;
		end
		else
		begin
			dll_bypassed_reg <= ~sync3_reg[BYP_BIT];
			rd_busy_reg <= rd_act_reg[0] | rd_act_reg[1];
			wr_busy_reg <= wr_act_reg[0] | wr_act_reg[1];
		end
	end

	assign link.rd_data_bus = q_out_reg;
	assign link.rd_data_oe = oe_out_reg;
	assign link.echo_timing_true = echo_t_reg;
	assign link.echo_timing_inverse = echo_i_reg;
endmodule

`default_nettype wire

// *** logic/sram_host_end.sv ***
// memory controller end: makes the input clock pair, issues bursts
`timescale 1ns/10ps
`default_nettype none
`include "sram_link_params.svh"

module sram_host_end #(
	parameter int K_HALF = `K_HALF_CYCLES
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link pins
	sram_link_if.host_end link,
	// user requests
	input wire logic bypass_req_n,
	input wire logic rd_req,
	input wire sram_link_pkg::addr_type rd_addr,
	output logic rd_ack_reg,
	input wire logic wr_req,
	input wire sram_link_pkg::addr_type wr_addr,
	input wire sram_link_pkg::burst_type wr_data,
	input wire sram_link_pkg::burst_mask_type wr_lane_n,
	output logic wr_ack_reg,
	// read return
	output sram_link_pkg::burst_type rd_data_reg,
	output logic rd_valid_reg
);
	import sram_link_pkg::*;

	localparam int PH_W = $clog2(2 * K_HALF);
	localparam int CAP_W = 3 + `DATA_W;

	logic [PH_W-1:0] ph_reg;
	logic [PH_W-1:0] ph_next;
	logic k_reg;
	logic kn_reg;
	logic tick_ph;
	logic launch_ph;
	logic issue_rd;
	logic issue_wr;
	cmd_kind_type cmd_kind;
	logic last_rd_reg;
	logic last_wr_reg;
	logic rd_n_reg;
	logic wr_n_reg;
	logic byp_n_reg;
	addr_type addr_reg;
	word_type sched_d_reg [0:`SCHED_LEN-1];
	lane_mask_type sched_m_reg [0:`SCHED_LEN-1];
	word_type d_reg;
	lane_mask_type m_reg;
	logic [CAP_W-1:0] cap1_reg;
	logic [CAP_W-1:0] cap2_reg;
	logic [CAP_W-1:0] cap3_reg;
	logic et_stable_reg;
	logic ei_stable_reg;
	logic et_rise;
	logic ei_rise;
	logic [`BURST_IDX_W-1:0] cap_cnt_reg;
	burst_type cap_buf_reg;

	// clock divider: true clock rises at phase zero, inverse is its opposite
	assign ph_next = (ph_reg == PH_W'(2 * K_HALF - 1)) ? '0 : ph_reg + 1'b1;
	assign tick_ph = (ph_reg == '0) || (ph_reg == PH_W'(K_HALF));
	assign launch_ph = (ph_reg == PH_W'(K_HALF / 2))
		|| (ph_reg == PH_W'(K_HALF + K_HALF / 2));

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ph_reg <= '0;
			k_reg <= 1'b0;
			kn_reg <= 1'b1;
		end
		else
		begin
			ph_reg <= ph_next;
			k_reg <= (ph_next < PH_W'(K_HALF));
			kn_reg <= ~(ph_next < PH_W'(K_HALF));
		end
	end

	// commands are set up mid-cycle so they are steady at the next true rise
	always_comb
	begin
		cmd_kind = CMD_NONE;
		if (rd_req && !last_rd_reg && wr_req && !last_wr_reg
			&& rd_addr == wr_addr)
			cmd_kind = CMD_BOTH;
		else if (rd_req && !last_rd_reg)
			cmd_kind = CMD_READ;
		else if (wr_req && !last_wr_reg)
			cmd_kind = CMD_WRITE;
	end

	assign issue_rd = (ph_reg == PH_W'(K_HALF))
		&& (cmd_kind == CMD_READ || cmd_kind == CMD_BOTH);
	assign issue_wr = (ph_reg == PH_W'(K_HALF))
		&& (cmd_kind == CMD_WRITE || cmd_kind == CMD_BOTH);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			addr_reg <= '0;
			last_rd_reg <= 1'b0;
			last_wr_reg <= 1'b0;
			rd_ack_reg <= 1'b0;
			wr_ack_reg <= 1'b0;
			byp_n_reg <= 1'b1;
		end
		else
		begin
			rd_ack_reg <= issue_rd;
			wr_ack_reg <= issue_wr;
			byp_n_reg <= bypass_req_n;
			if (ph_reg == PH_W'(K_HALF))
			begin
				rd_n_reg <= ~issue_rd;
				wr_n_reg <= ~issue_wr;
				last_rd_reg <= issue_rd;
				last_wr_reg <= issue_wr;
				if (issue_rd)
					addr_reg <= rd_addr;
				else if (issue_wr)
					addr_reg <= wr_addr;
			end
		end
	end

	// write schedule: slot j holds the word for the half tick j+1 ahead
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			for (int j = 0; j < `SCHED_LEN; j++)
			begin
				sched_d_reg[j] <= '0;
				sched_m_reg[j] <= '1;
			end
		end
		else if (tick_ph)
		begin
			for (int j = 0; j < `SCHED_LEN - 1; j++)
			begin
				sched_d_reg[j] <= sched_d_reg[j+1];
				sched_m_reg[j] <= sched_m_reg[j+1];
			end
			sched_d_reg[`SCHED_LEN-1] <= '0;
			sched_m_reg[`SCHED_LEN-1] <= '1;
			if (issue_wr)
			begin
				for (int w = 0; w < `BURST_LEN; w++)
				begin
					sched_d_reg[w + 2] <= wr_data[w*`DATA_W +: `DATA_W];
					sched_m_reg[w + 2] <= wr_lane_n[w*`LANES +: `LANES];
				end
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			d_reg <= '0;
			m_reg <= '1;
		end
		else if (launch_ph)
		begin
			d_reg <= sched_d_reg[0];
			m_reg <= sched_m_reg[0];
		end
	end

	// read capture: echo pins pass three flops like any outside input
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cap1_reg <= '0;
			cap2_reg <= '0;
			cap3_reg <= '0;
			et_stable_reg <= 1'b1;
			ei_stable_reg <= 1'b1;
		end
		else
		begin
			cap1_reg <= {link.echo_timing_true, link.echo_timing_inverse,
				link.rd_data_oe, link.rd_data_bus};
			cap2_reg <= cap1_reg;
			cap3_reg <= cap2_reg;
			if (cap2_reg[CAP_W-1] == cap3_reg[CAP_W-1])
				et_stable_reg <= cap3_reg[CAP_W-1];
			if (cap2_reg[CAP_W-2] == cap3_reg[CAP_W-2])
				ei_stable_reg <= cap3_reg[CAP_W-2];
		end
	end

	assign et_rise = cap2_reg[CAP_W-1] & cap3_reg[CAP_W-1] & ~et_stable_reg;
	assign ei_rise = cap2_reg[CAP_W-2] & cap3_reg[CAP_W-2] & ~ei_stable_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cap_cnt_reg <= '0;
			cap_buf_reg <= '0;
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			rd_valid_reg <= 1'b0;
			if ((et_rise || ei_rise) && cap3_reg[`DATA_W])
			begin
				cap_buf_reg[cap_cnt_reg*`DATA_W +: `DATA_W] <=
					cap3_reg[`DATA_W-1:0];
				cap_cnt_reg <= cap_cnt_reg + 1'b1;
				if (cap_cnt_reg == 2'h3)
				begin
					rd_data_reg <= {cap3_reg[`DATA_W-1:0],
						cap_buf_reg[3*`DATA_W-1:0]};
					rd_valid_reg <= 1'b1;
				end
			end
			else if (!cap3_reg[`DATA_W])
				cap_cnt_reg <= '0;
		end
	end

	assign link.in_clk_true = k_reg;
	assign link.in_clk_inverse = kn_reg;
	assign link.read_sel_n = rd_n_reg;
	assign link.write_sel_n = wr_n_reg;
	assign link.loop_bypass_n = byp_n_reg;
	assign link.sync_addr_bus = addr_reg;
	assign link.wr_data_bus = d_reg;
	assign link.byte_lane_write_n = m_reg;
endmodule

`default_nettype wire

// *** tb/sram_link_asserts.sv ***
// concurrent checks on the burst sram link pins
`timescale 1ns/10ps
`default_nettype none
`include "sram_link_params.svh"

module sram_link_asserts
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link pins
	input wire logic in_clk_true,
	input wire logic in_clk_inverse,
	input wire logic read_sel_n,
	input wire logic write_sel_n,
	input wire logic [`ADDR_W-1:0] sync_addr_bus,
	input wire logic rd_data_oe,
	input wire logic echo_timing_true
);
	int oe_run;
	int idle_cnt;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// length of the current output-enable run
	always_ff @(posedge sys_clk)
	begin
		if (rst || !rd_data_oe)
			oe_run <= 0;
		else
			oe_run <= oe_run + 1;
	end

	// cycles since the read select was last low
	always_ff @(posedge sys_clk)
	begin
		if (rst || !read_sel_n)
			idle_cnt <= 0;
		else if (idle_cnt < 1000)
			idle_cnt <= idle_cnt + 1;
	end

	// a select stays low one true-clock period, then lets go
	sequence rd_sel_held;
		!read_sel_n [*8] ##5 read_sel_n;
	endsequence

	inv_clock_a: assert property (in_clk_inverse == !in_clk_true)
		else $error("inverse clock not opposite");
	rd_sel_len_a: assert property ($fell(read_sel_n) |-> rd_sel_held)
		else $error("read select width wrong");
	addr_hold_a: assert property (
		(!read_sel_n && !$fell(read_sel_n)) ||
		(!write_sel_n && !$fell(write_sel_n)) |-> $stable(sync_addr_bus))
		else $error("address moved under select");
	rd_lat_a: assert property (
		$fell(read_sel_n) |-> ##[36:46] rd_data_oe)
		else $error("read data late");
	oe_cause_a: assert property (
		$rose(rd_data_oe) |-> $past(read_sel_n, 36) == 1'b0)
		else $error("read data without read select");
	oe_len_a: assert property (
		$fell(rd_data_oe) |-> (oe_run % 24) == 0)
		else $error("read burst length wrong");
	idle_quiet_a: assert property (idle_cnt > 64 |-> !rd_data_oe)
		else $error("read data while idle");
	echo_run_a: assert property (
		1'b1 |-> ##[1:16] $changed(echo_timing_true))
		else $error("echo clock stopped");
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench joining both ends of the burst sram link
`timescale 1ns/10ps
`default_nettype none

`define CHECK(what, exp, got) \
	begin \
		n_checks++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("wrong value %s expected %h seen %h", what, exp, got); \
		end \
	end

module tb_top;
	import sram_link_pkg::*;
	logic sys_clk;
	logic rst;
	logic bypass_req_n;
	logic rd_req;
	logic wr_req;
	addr_type rd_addr;
	addr_type wr_addr;
	burst_type wr_data;
	burst_mask_type wr_lane_n;
	logic rd_ack_reg;
	logic wr_ack_reg;
	burst_type rd_data_reg;
	logic rd_valid_reg;
	logic dll_bypassed_reg;
	logic rd_busy_reg;
	logic wr_busy_reg;
	int bad_count;
	int n_checks;
	int seed;
	int j;
	int k;
	logic [31:0] r;
	logic dirty;
	burst_type want;
	word_type mem [int];
	burst_type exp_q [$];
	addr_type pool [4];

	sram_link_if link_bus ();
	sram_device_end i_sram_device_end (.sys_clk(sys_clk), .rst(rst),
		.link(link_bus), .dll_bypassed_reg(dll_bypassed_reg),
		.rd_busy_reg(rd_busy_reg), .wr_busy_reg(wr_busy_reg));
	sram_host_end #(.K_HALF(6)) i_sram_host_end (.sys_clk(sys_clk),
		.rst(rst), .link(link_bus), .bypass_req_n(bypass_req_n),
		.rd_req(rd_req), .rd_addr(rd_addr), .rd_ack_reg(rd_ack_reg),
		.wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data),
		.wr_lane_n(wr_lane_n), .wr_ack_reg(wr_ack_reg),
		.rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg));
	sram_link_asserts i_sram_link_asserts (.sys_clk(sys_clk), .rst(rst),
		.in_clk_true(link_bus.in_clk_true),
		.in_clk_inverse(link_bus.in_clk_inverse),
		.read_sel_n(link_bus.read_sel_n),
		.write_sel_n(link_bus.write_sel_n),
		.sync_addr_bus(link_bus.sync_addr_bus),
		.rd_data_oe(link_bus.rd_data_oe),
		.echo_timing_true(link_bus.echo_timing_true));

	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic give_up();
		bad_count++;
		$display("wrong value wait expected %h seen %h", 1'b1, 1'b0);
		summarize();
	endtask

	// let every write in flight land before reading the array
	task automatic settle();
		int i;
		repeat (2)
		begin
			for (i = 0; i < 40 && wr_busy_reg !== 1'b1; i++)
				@(negedge sys_clk);
			for (i = 0; i < 200 && wr_busy_reg !== 1'b0; i++)
				@(negedge sys_clk);
		end
		if (wr_busy_reg !== 1'b0)
			give_up();
		dirty = 1'b0;
	endtask

	task automatic drain();
		int i;
		settle();
		for (i = 0; i < 400 && exp_q.size() > 0; i++)
			@(negedge sys_clk);
		if (exp_q.size() > 0)
			give_up();
	endtask

	// one read and/or write burst at one address; model updated in order
	task automatic issue(input bit do_rd, input bit do_wr, input bit full,
		input addr_type a);
		burst_type d;
		burst_type e;
		burst_mask_type m;
		logic rh;
		logic wh;
		int i;
		d = burst_type'({$random(seed), $random(seed), $random(seed),
			$random(seed), $random(seed)});
		m = full ? '0 : burst_mask_type'($random(seed));
		for (i = 0; i < 4; i++)
			e[36*i +: 36] = mem[a*4+i];
		if (do_rd)
			exp_q.push_back(e);
		if (do_wr)
		begin
			dirty = 1'b1;
			for (i = 0; i < 16; i++)
				if (!m[i])
					mem[a*4+i/4][9*(i%4) +: 9] = d[36*(i/4)+9*(i%4) +: 9];
		end
		@(negedge sys_clk);
		rd_req = do_rd;
		wr_req = do_wr;
		rd_addr = a;
		wr_addr = a;
		wr_data = d;
		wr_lane_n = m;
		for (i = 0; i < 200 && (rd_req || wr_req); i++)
		begin
			@(posedge sys_clk);
			rh = rd_ack_reg;
			wh = wr_ack_reg;
			@(negedge sys_clk);
			if (rh === 1'b1)
				rd_req = 1'b0;
			if (wh === 1'b1)
				wr_req = 1'b0;
		end
		if (rd_req || wr_req)
			give_up();
	endtask

	always @(posedge sys_clk)
	begin
		if (rd_valid_reg === 1'b1)
		begin
			if (exp_q.size() == 0)
				`CHECK("spare read", 1'b0, 1'b1)
			else
			begin
				want = exp_q.pop_front();
				`CHECK("read burst", want, rd_data_reg)
			end
		end
	end

	initial
	begin
		seed = 32'h1aa7;
		bad_count = 0;
		n_checks = 0;
		dirty = 1'b0;
		rst = 1'b1;
		bypass_req_n = 1'b1;
		rd_req = 1'b0;
		wr_req = 1'b0;
		rd_addr = '0;
		wr_addr = '0;
		wr_data = '0;
		wr_lane_n = '1;
		repeat (10) @(negedge sys_clk);
		rst = 1'b0;
		`CHECK("read enable", 1'b0, link_bus.rd_data_oe)
		`CHECK("bypass status", 1'b0, dll_bypassed_reg)
		for (j = 0; j < 4; j++)
			pool[j] = addr_type'($random(seed));
		for (j = 0; j < 4; j++)
			issue(1'b0, 1'b1, 1'b1, pool[j]);
		for (j = 0; j < 40; j++)
		begin
			if (j == 20)
			begin
				drain();
				bypass_req_n = 1'b0;
				for (k = 0; k < 50 && dll_bypassed_reg !== 1'b1; k++)
					@(negedge sys_clk);
				`CHECK("bypass status", 1'b1, dll_bypassed_reg)
				`CHECK("bypass pin", 1'b0, link_bus.loop_bypass_n)
			end
			r = $random(seed);
			if (r[2:1] != 2'b00 && dirty)
				settle();
			case (r[2:1])
				2'b00: issue(1'b0, 1'b1, 1'b0, pool[r[4:3]]);
				2'b01: issue(1'b1, 1'b0, 1'b0, pool[r[4:3]]);
				2'b10:
				begin
					issue(1'b1, 1'b0, 1'b0, pool[r[4:3]]);
					issue(1'b1, 1'b0, 1'b0, pool[r[6:5]]);
				end
				default: issue(1'b1, 1'b1, 1'b0, pool[r[4:3]]);
			endcase
		end
		drain();
		summarize();
	end
endmodule

`default_nettype wire
